/* core/osc_ctrl_pkg.sv */
// package of register map, field positions and timing for the rtc oscillator control block
`default_nettype none
package osc_ctrl_pkg;
  // byte addresses: printed offsets are not multiples of four, so they are indices
  localparam logic [3:0] IDX_CONTROL = 4'h5;
  localparam logic [3:0] IDX_CONFIG = 4'h6;
  localparam logic [3:0] IDX_PIN = 4'h7;
  localparam logic [3:0] IDX_STATUS = 4'h8;
  localparam logic [3:0] IDX_MASK = 4'h9;
  localparam logic [5:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
  localparam logic [5:0] ADDR_CONFIG = {IDX_CONFIG, 2'b00};
  localparam logic [5:0] ADDR_PIN = {IDX_PIN, 2'b00};
  localparam logic [5:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [5:0] ADDR_MASK = {IDX_MASK, 2'b00};
  // control register fields
  localparam int CTL_GAIN_BIT = 7;
  localparam int CTL_MODE_BIT = 6;
  localparam int CTL_BIAS_BIT = 5;
  localparam int CTL_VALID_BIT = 4;
  localparam int CTL_LFO_BIT = 3;
  // configuration register fields
  localparam int CFG_STEP_BIT = 7;
  localparam int CFG_READY_BIT = 6;
  localparam int CAP_W = 4;
  // pin register field
  localparam int PIN_SHORT_BIT = 7;
  // status and mask bits: 0 amplitude gained, 1 amplitude lost, 2 cap reached target
  localparam int IRQ_W = 3;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [CAP_W-1:0] CAP_RESET = 4'h0;
  localparam logic [6:0] PIN_RSVD_RESET = 7'h00;
  localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;
  // one capacitance step per interval
  localparam int CLK_HZ = 50_000_000;
  localparam int STEP_US = 10;
  localparam int STEP_CYCLES = CLK_HZ / 1_000_000 * STEP_US;
  localparam int STEP_CNT_W = 9;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

/* core/osc_sync2.sv */
// two flip-flop synchroniser for a level from the analog side
`default_nettype none
module osc_sync2 (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic din,
  output logic dout
);
  logic meta_r;

  // first stage is read only by the second
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* core/cap_stepper.sv */
// load capacitance stepper: moves the applied value one code per interval
`default_nettype none
module cap_stepper (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic step_enable,
  input wire logic [osc_ctrl_pkg::CAP_W-1:0] target,
  output logic [osc_ctrl_pkg::CAP_W-1:0] applied,
  output logic at_target
);
  logic [osc_ctrl_pkg::STEP_CNT_W-1:0] tick_r;
  logic tick;

  localparam logic [osc_ctrl_pkg::STEP_CNT_W-1:0] TICK_LAST =
    osc_ctrl_pkg::STEP_CNT_W'(osc_ctrl_pkg::STEP_CYCLES - 1);

  assign tick = (tick_r == TICK_LAST);

  // interval divider, one-cycle enable
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      tick_r <= '0;
    else if (tick)
      tick_r <= '0;
    else
      tick_r <= tick_r + 1'b1;
  end

  // stepping on: walk one code per tick; off: jump straight to target
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      applied <= osc_ctrl_pkg::CAP_RESET;
    else if (!step_enable)
      applied <= target;
    else if (tick && applied < target)
      applied <= applied + 1'b1;
    else if (tick && applied > target)
      applied <= applied - 1'b1;
  end

  // ready flag registered from the comparison
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      at_target <= 1'b1;
    else
      at_target <= (applied == target);
  end
endmodule
`default_nettype wire

/* core/osc_ctrl.sv */
// rtc oscillator control and status registers behind an axi4-lite slave
//
// Design decision made here: the AXI4-Lite slave port.
`default_nettype none
module osc_ctrl (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic amplitude_ok,
  output logic gain_control_enable,
  output logic crystal_mode_select,
  output logic bias_double_enable,
  output logic internal_low_freq_osc,
  output logic [3:0] cap_applied,
  output logic crystal_pin_short,
  output logic irq
);
  logic aw_held_r;
  logic w_held_r;
  logic [5:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;
  logic wr_lane0;
  logic [7:0] wbyte;
  logic [7:0] control_r;
  logic step_en_r;
  logic [3:0] cap_target_r;
  logic pin_short_r;
  logic [6:0] pin_rsvd_r;
  logic [2:0] status_r;
  logic [2:0] mask_r;
  logic [2:0] event_set;
  logic amp_valid;
  logic amp_valid_d_r;
  logic at_target;
  logic at_target_d_r;
  logic [3:0] cap_now;
  logic [7:0] rd_byte;
  logic rd_hit;

  // amplitude detector comes from the analog domain
  osc_sync2 amp_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .din(amplitude_ok),
    .dout(amp_valid)
  );

  cap_stepper stepper (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .step_enable(step_en_r),
    .target(cap_target_r),
    .applied(cap_now),
    .at_target(at_target)
  );

  // write address and data are taken independently, in either order
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held_r <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
    else if (do_write)
      w_held_r <= 1'b0;
  end

  // ready stays low while a write is held or its response is pending
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_lane0 = do_write && wstrb_r[0];
  assign wbyte = wdata_r[7:0];

  // write response; unmapped byte addresses answer slverr
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= osc_ctrl_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      case (awaddr_r)
        osc_ctrl_pkg::ADDR_CONTROL, osc_ctrl_pkg::ADDR_CONFIG, osc_ctrl_pkg::ADDR_PIN,
        osc_ctrl_pkg::ADDR_STATUS, osc_ctrl_pkg::ADDR_MASK: s_axi_bresp <= osc_ctrl_pkg::RESP_OKAY;
        default: s_axi_bresp <= osc_ctrl_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // control register: only the three writable bits are stored
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      control_r <= osc_ctrl_pkg::CONTROL_RESET;
    else if (wr_lane0 && awaddr_r == osc_ctrl_pkg::ADDR_CONTROL)
    begin
      control_r[osc_ctrl_pkg::CTL_GAIN_BIT] <= wbyte[osc_ctrl_pkg::CTL_GAIN_BIT];
      control_r[osc_ctrl_pkg::CTL_MODE_BIT] <= wbyte[osc_ctrl_pkg::CTL_MODE_BIT];
      control_r[osc_ctrl_pkg::CTL_BIAS_BIT] <= wbyte[osc_ctrl_pkg::CTL_BIAS_BIT];
    end
  end

  // the low-frequency select is read-only on the bus, so it stays at reset here
  // and is held as a plain flop to keep the override path in place

  // configuration register: step enable and target, upper unused bits not stored
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      step_en_r <= 1'b0;
      cap_target_r <= osc_ctrl_pkg::CAP_RESET;
    end
    else if (wr_lane0 && awaddr_r == osc_ctrl_pkg::ADDR_CONFIG)
    begin
      step_en_r <= wbyte[osc_ctrl_pkg::CFG_STEP_BIT];
      cap_target_r <= wbyte[osc_ctrl_pkg::CAP_W-1:0];
    end
  end

  // pin register: reserved bits kept so read-modify-write round-trips
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_short_r <= 1'b0;
      pin_rsvd_r <= osc_ctrl_pkg::PIN_RSVD_RESET;
    end
    else if (wr_lane0 && awaddr_r == osc_ctrl_pkg::ADDR_PIN)
    begin
      pin_short_r <= wbyte[osc_ctrl_pkg::PIN_SHORT_BIT];
      pin_rsvd_r <= wbyte[6:0];
    end
  end

  // events: amplitude gained, amplitude lost, capacitance reached target
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      amp_valid_d_r <= 1'b0;
      at_target_d_r <= 1'b1;
    end
    else
    begin
      amp_valid_d_r <= amp_valid;
      at_target_d_r <= at_target;
    end
  end

  assign event_set = {at_target && !at_target_d_r, !amp_valid && amp_valid_d_r, amp_valid && !amp_valid_d_r};

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      status_r <= '0;
    else if (wr_lane0 && awaddr_r == osc_ctrl_pkg::ADDR_STATUS)
      status_r <= (status_r & ~wbyte[2:0]) | event_set;
    else
      status_r <= status_r | event_set;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      mask_r <= osc_ctrl_pkg::MASK_RESET;
    else if (wr_lane0 && awaddr_r == osc_ctrl_pkg::ADDR_MASK)
      mask_r <= wbyte[2:0];
  end

  // read mux; unused fields read zero
  always_comb
  begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      osc_ctrl_pkg::ADDR_CONTROL: rd_byte = {control_r[7:5], amp_valid, 1'b0, 3'b000};
      osc_ctrl_pkg::ADDR_CONFIG: rd_byte = {step_en_r, at_target, 2'b00, cap_target_r};
      osc_ctrl_pkg::ADDR_PIN: rd_byte = {pin_short_r, pin_rsvd_r};
      osc_ctrl_pkg::ADDR_STATUS: rd_byte = {5'h00, status_r};
      osc_ctrl_pkg::ADDR_MASK: rd_byte = {5'h00, mask_r};
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  // read channel: one cycle from address taken to data valid
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= osc_ctrl_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_hit ? osc_ctrl_pkg::RESP_OKAY : osc_ctrl_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // oscillator control outputs, registered
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gain_control_enable <= 1'b0;
      crystal_mode_select <= 1'b0;
      bias_double_enable <= 1'b0;
      internal_low_freq_osc <= 1'b0;
      cap_applied <= osc_ctrl_pkg::CAP_RESET;
      crystal_pin_short <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      gain_control_enable <= control_r[osc_ctrl_pkg::CTL_GAIN_BIT];
      internal_low_freq_osc <= control_r[osc_ctrl_pkg::CTL_LFO_BIT];
      // low-frequency select overrides the mode choice
      crystal_mode_select <= control_r[osc_ctrl_pkg::CTL_MODE_BIT] && !control_r[osc_ctrl_pkg::CTL_LFO_BIT];
      bias_double_enable <= control_r[osc_ctrl_pkg::CTL_BIAS_BIT];
      cap_applied <= cap_now;
      crystal_pin_short <= pin_short_r;
      irq <= |(status_r & mask_r);
    end
  end

  // assertions
  ctl_low_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready && s_axi_araddr == osc_ctrl_pkg::ADDR_CONTROL)
    |-> s_axi_rdata[3:0] == 4'h0)
    else $error("control low bits not zero");
  cfg_gap_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready && s_axi_araddr == osc_ctrl_pkg::ADDR_CONFIG)
    |-> s_axi_rdata[5:4] == 2'b00)
    else $error("config unused bits not zero");
  gain_follow_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_lane0 && awaddr_r == osc_ctrl_pkg::ADDR_CONTROL |-> ##2 gain_control_enable == $past(wbyte[7], 2))
    else $error("gain enable did not follow write");
  mode_override_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    control_r[3] |=> !crystal_mode_select)
    else $error("low freq select did not override mode");
  mode_follow_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !control_r[3] |=> crystal_mode_select == $past(control_r[6]))
    else $error("mode output wrong");
  bias_follow_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    1'b1 |=> bias_double_enable == $past(control_r[5]))
    else $error("bias output wrong");
  amp_report_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready && s_axi_araddr == osc_ctrl_pkg::ADDR_CONTROL)
    |-> s_axi_rdata[4] == $past(amp_valid))
    else $error("amplitude flag misreported");
  ready_low_step_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    cap_now != cap_target_r ##1 cap_now != cap_target_r |-> !at_target)
    else $error("ready high while stepping");
  single_step_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    step_en_r && $past(step_en_r) && cap_now != $past(cap_now)
    |-> (cap_now == $past(cap_now) + 4'h1) || (cap_now == $past(cap_now) - 4'h1))
    else $error("capacitance jumped more than one step");
  target_store_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_lane0 && awaddr_r == osc_ctrl_pkg::ADDR_CONFIG |=> cap_target_r == $past(wbyte[3:0]))
    else $error("target not stored");
  pin_short_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    1'b1 |=> crystal_pin_short == $past(pin_short_r))
    else $error("pin short output wrong");
  step_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !step_en_r |=> cap_now == $past(cap_target_r))
    else $error("capacitance not applied directly");

  step_cover_c: cover property (@(posedge sys_clk) disable iff (!resetn) step_en_r && !at_target ##[1:1000] at_target);
  irq_cover_c: cover property (@(posedge sys_clk) disable iff (!resetn) irq);
  amp_cover_c: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(amp_valid));
endmodule
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the rtc oscillator control block over axi4-lite
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TIMEOUT_CYCLES = 20000;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [5:0] s_axi_araddr = 6'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic amplitude_ok = 1'b0;
  logic gain_control_enable;
  logic crystal_mode_select;
  logic bias_double_enable;
  logic internal_low_freq_osc;
  logic [3:0] cap_applied;
  logic crystal_pin_short;
  logic irq;
  logic [3:0] prev_cap = 4'h0;
  logic step_on = 1'b0;
  logic [31:0] rd;
  logic [1:0] rr;
  logic [7:0] ctl_vals [6] = '{8'h80, 8'h40, 8'h20, 8'h48, 8'h07, 8'hff};
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  int elapsed = 0;
  int last_step = 0;

  osc_ctrl u_osc_ctrl (.sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .amplitude_ok,
    .gain_control_enable, .crystal_mode_select, .bias_double_enable, .internal_low_freq_osc, .cap_applied,
    .crystal_pin_short, .irq);

  always #10 sys_clk = ~sys_clk;

  task automatic summarize();
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // let some edges pass, then stop mid-cycle where outputs are settled
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // readiness is looked at mid-cycle: it cannot move before the next edge, which is where it is taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw_hs;
    logic w_hs;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // the releases below are not yet visible here, so the handshake flags decide
    do
    begin
      @(negedge sys_clk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      @(posedge sys_clk);
      if (aw_hs)
        s_axi_awvalid <= 1'b0;
      if (w_hs)
        s_axi_wvalid <= 1'b0;
    end
    while ((s_axi_awvalid && !aw_hs) || (s_axi_wvalid && !w_hs));
    // no limit of its own: only the bench timeout ends a hung wait
    @(negedge sys_clk);
    while (s_axi_bvalid !== 1'b1)
      @(negedge sys_clk);
    chk({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
    @(posedge sys_clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdreg(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge sys_clk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      @(posedge sys_clk);
      if (ar_hs)
        s_axi_arvalid <= 1'b0;
    end
    while (!ar_hs);
    @(negedge sys_clk);
    while (s_axi_rvalid !== 1'b1)
      @(negedge sys_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge sys_clk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0] r;
    rdreg(a, d, r);
    chk({30'h0, r}, {30'h0, osc_ctrl_pkg::RESP_OKAY}, what);
    chk(d, exp, what);
  endtask

  // cycle ceiling against a hung handshake
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == TIMEOUT_CYCLES)
    begin
      n_fail++;
      summarize();
    end
  end

  // while stepping, the applied code may only move down by one, one full interval apart;
  // elapsed counts from the moment stepping is announced, so tick phase cannot fool the bounds
  always @(negedge sys_clk)
  begin
    if (step_on)
      elapsed++;
    if (step_on && cap_applied !== prev_cap)
    begin
      chk({31'h0, (cap_applied - prev_cap) == 4'hf}, 32'h0000_0001, "step size");
      if (last_step > 0)
        chk(elapsed - last_step, osc_ctrl_pkg::STEP_CYCLES, "step interval");
      last_step = elapsed;
    end
    prev_cap = cap_applied;
  end

  initial
  begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    rdchk(osc_ctrl_pkg::ADDR_CONTROL, 32'h0000_0000, "control reset");
    rdchk(osc_ctrl_pkg::ADDR_CONFIG, 32'h0000_0040, "config reset");
    rdchk(osc_ctrl_pkg::ADDR_PIN, 32'h0000_0000, "pin reset");
    rdchk(osc_ctrl_pkg::ADDR_MASK, 32'h0000_0000, "mask reset");
    // gain, mode and bias each alone, mode with the low-frequency bit, the low bits, then all bits at once
    foreach (ctl_vals[i])
    begin
      wr(osc_ctrl_pkg::ADDR_CONTROL, {24'hff_ffff, ctl_vals[i]}, 4'hf, osc_ctrl_pkg::RESP_OKAY);
      settle(2);
      chk(32'(gain_control_enable), 32'(ctl_vals[i][7]), "gain enable");
      chk(32'(crystal_mode_select), 32'(ctl_vals[i][6]), "mode select");
      chk(32'(bias_double_enable), 32'(ctl_vals[i][5]), "bias double");
      chk(32'(internal_low_freq_osc), 32'h0000_0000, "low freq select");
      rdchk(osc_ctrl_pkg::ADDR_CONTROL, {24'h0, ctl_vals[i] & 8'he0}, "control readback");
    end
    // a write with no lane enabled leaves the register alone
    wr(osc_ctrl_pkg::ADDR_CONTROL, 32'h0000_0000, 4'h0, osc_ctrl_pkg::RESP_OKAY);
    rdchk(osc_ctrl_pkg::ADDR_CONTROL, 32'h0000_00e0, "lane zero ignored");
    wr(osc_ctrl_pkg::ADDR_CONTROL, 32'h0000_0000, 4'hf, osc_ctrl_pkg::RESP_OKAY);
    // amplitude gained: status bit0, interrupt only once unmasked
    amplitude_ok <= 1'b1;
    settle(5);
    chk(32'(irq), 32'h0000_0000, "irq masked");
    rdchk(osc_ctrl_pkg::ADDR_CONTROL, 32'h0000_0010, "amplitude valid");
    rdchk(osc_ctrl_pkg::ADDR_STATUS, 32'h0000_0001, "status gained");
    wr(osc_ctrl_pkg::ADDR_MASK, 32'h0000_0007, 4'hf, osc_ctrl_pkg::RESP_OKAY);
    settle(2);
    chk(32'(irq), 32'h0000_0001, "irq unmasked");
    wr(osc_ctrl_pkg::ADDR_STATUS, 32'h0000_0001, 4'hf, osc_ctrl_pkg::RESP_OKAY);
    settle(2);
    chk(32'(irq), 32'h0000_0000, "irq cleared");
    amplitude_ok <= 1'b0;
    settle(5);
    rdchk(osc_ctrl_pkg::ADDR_CONTROL, 32'h0000_0000, "amplitude lost");
    rdchk(osc_ctrl_pkg::ADDR_STATUS, 32'h0000_0002, "status lost");
    chk(32'(irq), 32'h0000_0001, "irq on loss");
    // stepping off: target applied at once, unused bits dropped
    wr(osc_ctrl_pkg::ADDR_CONFIG, 32'h0000_003f, 4'hf, osc_ctrl_pkg::RESP_OKAY);
    settle(3);
    chk(32'(cap_applied), 32'h0000_000f, "direct apply");
    rdchk(osc_ctrl_pkg::ADDR_CONFIG, 32'h0000_004f, "config readback");
    wr(osc_ctrl_pkg::ADDR_STATUS, 32'h0000_0007, 4'hf, osc_ctrl_pkg::RESP_OKAY);
    // stepping on: thirteen single steps down, ready low meanwhile
    step_on <= 1'b1;
    wr(osc_ctrl_pkg::ADDR_CONFIG, 32'h0000_0082, 4'hf, osc_ctrl_pkg::RESP_OKAY);
    rdchk(osc_ctrl_pkg::ADDR_CONFIG, 32'h0000_0082, "ready low while stepping");
    while (cap_applied !== 4'h2)
      @(negedge sys_clk);
    chk(32'(elapsed >= 12 * osc_ctrl_pkg::STEP_CYCLES), 32'h0000_0001, "step pacing");
    chk(32'(elapsed <= 13 * osc_ctrl_pkg::STEP_CYCLES + 20), 32'h0000_0001, "step reach");
    step_on <= 1'b0;
    settle(3);
    rdchk(osc_ctrl_pkg::ADDR_CONFIG, 32'h0000_00c2, "ready at target");
    // loss flag was cleared before stepping, so only the reached-target event remains
    rdchk(osc_ctrl_pkg::ADDR_STATUS, 32'h0000_0004, "status reached");
    // pin short, then read-modify-write back to normal keeping reserved bits
    wr(osc_ctrl_pkg::ADDR_PIN, 32'h0000_00d5, 4'hf, osc_ctrl_pkg::RESP_OKAY);
    settle(2);
    chk(32'(crystal_pin_short), 32'h0000_0001, "pins shorted");
    rdreg(osc_ctrl_pkg::ADDR_PIN, rd, rr);
    wr(osc_ctrl_pkg::ADDR_PIN, rd & 32'h0000_007f, 4'hf, osc_ctrl_pkg::RESP_OKAY);
    settle(2);
    chk(32'(crystal_pin_short), 32'h0000_0000, "pins normal");
    rdchk(osc_ctrl_pkg::ADDR_PIN, 32'h0000_0055, "reserved kept");
    // unmapped places answer with an error and no data
    wr(6'h3c, 32'h0000_00ff, 4'hf, osc_ctrl_pkg::RESP_SLVERR);
    rdreg(6'h00, rd, rr);
    chk({30'h0, rr}, {30'h0, osc_ctrl_pkg::RESP_SLVERR}, "unmapped read resp");
    chk(rd, 32'h0000_0000, "unmapped read data");
    summarize();
  end
endmodule
`default_nettype wire
